/* gsc_sensor_host.sv */
// Host controller that drives the gas sensor over its two-wire pins.
// Assumes a single sensor, pull-ups on SDA and SCL, commands from same-clock logic.
//
// What this block does
// - Run the serial clock at fast mode, never above 400 kHz.
// - Send each command as exactly two bytes with no checksum.
// - Move parameters and results as two data bytes plus one checksum.
// - Checksum is CRC-8, poly 0x31, init 0xFF, no reflection, no final XOR.
// - Measure sends 6 parameter bytes; responses are 3, 3, 9 or none.
// - Master should repeat the measurement about once a second, hotplate on; this block measures only when a command arrives.
// - Self-check result is one word plus checksum, readable after 320 ms.
// - Master waits the maximum time, or polls read headers until acknowledged.
// - Master acknowledges each byte but the last; sensor stops on any missing ack.
// - Master ends reads with NACK and STOP after the last byte.
// - Defaults are 0x8000 with 0xA2 and 0x6666 with 0x93.
// - Master sends humidity and temperature ticks given at its inputs, or the defaults when compensation is off.
`timescale 1ns/100ps
module gsc_sensor_host
   import gsc_pkg::*;
#(
   parameter int unsigned P_SCL_QTR_CYC = SCL_QTR_CYC,
   parameter int unsigned P_PWRUP_CYC   = PWRUP_CYC,
   parameter int unsigned P_MEAS_CYC    = MEAS_CYC,
   parameter int unsigned P_TEST_CYC    = TEST_CYC,
   parameter int unsigned P_SHORT_CYC   = SHORT_CYC,
   parameter int unsigned P_POLL_CYC    = P_SHORT_CYC   // Retry gap follows the short wait unless set apart
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_cmd_valid,
   input  wire gsc_cmd_type i_cmd_sel,
   input  wire logic        i_comp_en,
   input  wire logic [15:0] i_rh_ticks,
   input  wire logic [15:0] i_temp_ticks,
   input  wire logic        i_sda,
   input  wire logic        i_scl,
   output logic             o_sda_out,
   output logic             o_sda_oe,
   output logic             o_scl_out,
   output logic             o_scl_oe,
   output logic             o_ready,
   output logic             o_done,
   output logic [47:0]      o_result,
   output logic             o_crc_ok,
   output logic             o_nack_err,
   output logic             o_self_pass,
   output logic             o_hotplate_on
);
   gsc_byte_if link_bus ();

   gsc_state_type state;
   gsc_state_type after_wait;
   gsc_cmd_type   cmd;
   logic          comp;
   logic [15:0]   rh;
   logic [15:0]   tmp;
   logic          issued;
   logic [3:0]    byte_idx;
   logic [31:0]   wait_cnt;
   logic [7:0]    poll_cnt;
   logic          cmd_err;
   logic [71:0]   rx_buf;

   logic          is_meas, is_serial, op_active, last_wr, last_rd, poll_over;
   logic [3:0]    wr_len, rd_len;
   logic [15:0]   cmd_code, rh_word, tmp_word;
   logic [31:0]   exec_cyc;
   logic [71:0]   wr_frame, wr_shift;
   logic [7:0]    tx_byte, rd_hdr;
   logic [2:0]    word_ok;
   logic          resp_ok;

   // Command decode
   assign is_meas   = (cmd == measure_raw_cmd);
   assign is_serial = (cmd == read_unique_id_cmd);
   assign cmd_code  = is_meas ? MEASURE_CODE :
                      is_serial ? UNIQUE_ID_CODE :
                      (cmd == run_self_check_cmd) ? SELF_CHECK_CODE : HOTPLATE_CODE;
   assign wr_len    = is_meas ? MEAS_WR_LEN : CMD_WR_LEN;
   assign rd_len    = is_serial ? SERIAL_RESP_LEN :
                      (cmd == hotplate_off_cmd) ? NO_RESP_LEN : WORD_RESP_LEN;
   // Wait the worst-case time so a single read header normally succeeds
   assign exec_cyc  = is_meas ? 32'(P_MEAS_CYC) :
                      (cmd == run_self_check_cmd) ? 32'(P_TEST_CYC) : 32'(P_SHORT_CYC);

   // Outgoing frame: header, command, then two checksummed parameter words
   assign rh_word  = comp ? rh : DEFAULT_RH;
   assign tmp_word = comp ? tmp : DEFAULT_TEMP;
   assign wr_frame = {DEV_ADDR, RW_WRITE, cmd_code,
                      rh_word, gsc_crc8(rh_word), tmp_word, gsc_crc8(tmp_word)};
   assign wr_shift = wr_frame << {byte_idx, 3'b000};
   assign tx_byte  = wr_shift[71:64];
   assign rd_hdr   = {DEV_ADDR, RW_READ};

   // Requests to the bit engine
   assign op_active = (state == m_start) || (state == m_wbyte) || (state == m_wstop) ||
                      (state == m_rstart) || (state == m_rbyte) || (state == m_rstop);
   assign link_bus.op_valid = op_active && !issued;
   assign link_bus.op = ((state == m_start) || (state == m_rstart)) ? op_start :
                        ((state == m_wstop) || (state == m_rstop)) ? op_stop :
                        ((state == m_rbyte) && (byte_idx != 4'h0)) ? op_read : op_write;
   assign link_bus.wdata    = (state == m_rbyte) ? rd_hdr : tx_byte;
   assign link_bus.send_ack = (byte_idx != rd_len);

   assign last_wr   = (byte_idx == wr_len - 4'h1);
   assign last_rd   = (byte_idx == rd_len);
   assign poll_over = (poll_cnt == 8'(POLL_LIMIT));

   // Per-word checksum check, lowest word is the last one received
   generate
      for (genvar w = 0; w < 3; w++)
      begin : g_word_check
         assign word_ok[w] = (gsc_crc8(rx_buf[24 * w + 8 +: 16]) == rx_buf[24 * w +: 8]);
      end
   endgenerate
   // A re-read or over-read returns all ones, which fails the checksum
   assign resp_ok = (rd_len == NO_RESP_LEN) || (is_serial ? (&word_ok) : word_ok[0]);

   // Bit engine, owns the pin timing
   gsc_bit_engine #(
      .P_QTR_CYC (P_SCL_QTR_CYC)
   ) u_engine (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_sda     (i_sda),
      .i_scl     (i_scl),
      .o_sda_oe  (o_sda_oe),
      .o_scl_oe  (o_scl_oe),
      .bus       (link_bus.engine)
   );

   // Transaction sequencer
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state <= m_powerup; after_wait <= m_idle; cmd <= measure_raw_cmd; comp <= 1'b0;
         rh <= 16'h0000; tmp <= 16'h0000; issued <= 1'b0; byte_idx <= 4'h0;
         wait_cnt <= 32'(P_PWRUP_CYC); poll_cnt <= 8'h00; cmd_err <= 1'b0;
      end
      else
      begin
         if (link_bus.op_valid)
            issued <= 1'b1;
         else if (link_bus.done)
            issued <= 1'b0;
         case (state)
            m_powerup:
            begin
               if (wait_cnt == 32'h0000_0000)
                  state <= m_idle;
               else
                  wait_cnt <= wait_cnt - 32'h0000_0001;
            end
            m_idle:
            begin
               if (i_cmd_valid)
               begin
                  cmd <= i_cmd_sel; comp <= i_comp_en; rh <= i_rh_ticks; tmp <= i_temp_ticks;
                  cmd_err <= 1'b0; poll_cnt <= 8'h00; state <= m_start;
               end
            end
            m_start, m_rstart:
            begin
               if (link_bus.done)
               begin
                  byte_idx <= 4'h0;
                  state    <= (state == m_start) ? m_wbyte : m_rbyte;
               end
            end
            m_wbyte:
            begin
               if (link_bus.done && !link_bus.got_ack)
               begin
                  // Header refused means busy: retry later; a refused command byte is fatal
                  cmd_err    <= (byte_idx != 4'h0) || poll_over;
                  poll_cnt   <= poll_cnt + 8'h01;
                  wait_cnt   <= 32'(P_POLL_CYC);
                  after_wait <= m_start;
                  state      <= m_wstop;
               end
               else if (link_bus.done && last_wr)
               begin
                  // Execution runs from the ack of the last byte
                  wait_cnt   <= exec_cyc;
                  after_wait <= (rd_len == NO_RESP_LEN) ? m_finish : m_rstart;
                  state      <= m_wstop;
               end
               else if (link_bus.done)
                  byte_idx <= byte_idx + 4'h1;
            end
            m_wstop, m_rstop:
            begin
               if (link_bus.done)
                  state <= cmd_err ? m_finish : m_exec;
            end
            m_exec:
            begin
               if (wait_cnt == 32'h0000_0000)
                  state <= after_wait;
               else
                  wait_cnt <= wait_cnt - 32'h0000_0001;
            end
            m_rbyte:
            begin
               if (link_bus.done && (byte_idx == 4'h0) && !link_bus.got_ack)
               begin
                  // Result not ready yet: poll the read header again
                  cmd_err    <= poll_over;
                  poll_cnt   <= poll_cnt + 8'h01;
                  wait_cnt   <= 32'(P_POLL_CYC);
                  after_wait <= m_rstart;
                  state      <= m_rstop;
               end
               else if (link_bus.done && last_rd)
               begin
                  wait_cnt   <= 32'h0000_0000;
                  after_wait <= m_finish;
                  state      <= m_rstop;
               end
               else if (link_bus.done)
                  byte_idx <= byte_idx + 4'h1;
            end
            m_finish:
               state <= m_idle;
            default:
               state <= m_idle;
         endcase
      end
   end

   // Response capture, one word per three bytes
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rx_buf <= 72'h0;
      else if ((state == m_idle) && i_cmd_valid)
         rx_buf <= 72'h0;
      else if ((state == m_rbyte) && link_bus.done && (byte_idx != 4'h0))
         rx_buf <= {rx_buf[63:0], link_bus.rdata};
   end

   // User-side results; pin data levels are always low, enables do the work
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_ready <= 1'b0; o_done <= 1'b0; o_result <= 48'h0; o_crc_ok <= 1'b0;
         o_nack_err <= 1'b0; o_self_pass <= 1'b0; o_hotplate_on <= 1'b0;
         o_sda_out <= 1'b0; o_scl_out <= 1'b0;
      end
      else
      begin
         o_sda_out <= 1'b0;
         o_scl_out <= 1'b0;
         o_done    <= (state == m_finish);
         o_ready   <= (state == m_finish) || ((state == m_idle) && !i_cmd_valid);
         if (state == m_finish)
         begin
            o_result    <= is_serial ? {rx_buf[71:56], rx_buf[47:32], rx_buf[23:8]} :
                                       {32'h0, rx_buf[23:8]};
            o_crc_ok    <= !cmd_err && resp_ok;
            o_nack_err  <= cmd_err;
            o_self_pass <= (cmd == run_self_check_cmd) && !cmd_err && word_ok[0] &&
                           (rx_buf[23:16] == SELF_PASS_BYTE);
            // Mirror of the sensor mode; self-check leaves it as it was
            if (!cmd_err && is_meas)
               o_hotplate_on <= 1'b1;
            else if (!cmd_err && (cmd == hotplate_off_cmd))
               o_hotplate_on <= 1'b0;
         end
      end
   end

endmodule : gsc_sensor_host

/* gsc_pkg.sv */
// Shared constants, types and checksum helper for the gas sensor host.
// Assumes a 125 MHz system clock and one sensor on an open-drain two-wire bus.
package gsc_pkg;

   // Clock and link timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned NS_PER_US     = 1000;
   localparam int unsigned NS_PER_MS     = 1000000;
   localparam int unsigned SCL_PERIOD_NS = 2500;   // 400 kHz fast mode
   localparam int unsigned SCL_QTR_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int unsigned PWRUP_US      = 600;
   localparam int unsigned MEAS_MS       = 30;
   localparam int unsigned TEST_MS       = 320;
   localparam int unsigned SHORT_MS      = 1;
   localparam int unsigned POLL_MS       = 1;
   localparam int unsigned PWRUP_CYC     = (PWRUP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MEAS_CYC      = (MEAS_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TEST_CYC      = (TEST_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SHORT_CYC     = (SHORT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POLL_CYC      = (POLL_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POLL_LIMIT    = 64;

   // Addressing and command codes
   localparam logic [6:0]  DEV_ADDR        = 7'h59;
   localparam logic        RW_WRITE        = 1'h0;
   localparam logic        RW_READ         = 1'h1;
   localparam logic [15:0] MEASURE_CODE    = 16'h260f;
   localparam logic [15:0] SELF_CHECK_CODE = 16'h280e;
   localparam logic [15:0] HOTPLATE_CODE   = 16'h3615;
   localparam logic [15:0] UNIQUE_ID_CODE  = 16'h3682;
   localparam logic [15:0] DEFAULT_RH      = 16'h8000;
   localparam logic [15:0] DEFAULT_TEMP    = 16'h6666;
   localparam logic [7:0]  SELF_PASS_BYTE  = 8'hd4;

   // Frame lengths in bytes, header counted on the write side only
   localparam logic [3:0]  MEAS_WR_LEN     = 4'h9;
   localparam logic [3:0]  CMD_WR_LEN      = 4'h3;
   localparam logic [3:0]  WORD_RESP_LEN   = 4'h3;
   localparam logic [3:0]  SERIAL_RESP_LEN = 4'h9;
   localparam logic [3:0]  NO_RESP_LEN     = 4'h0;
   localparam logic [3:0]  BYTE_BITS       = 4'h8;

   // Checksum definition
   localparam logic [7:0]  CRC_INIT = 8'hff;
   localparam logic [7:0]  CRC_POLY = 8'h31;
   localparam logic [7:0]  CRC_XOR  = 8'h00;

   typedef enum logic [1:0] {
      measure_raw_cmd    = 2'b00,
      run_self_check_cmd = 2'b01,
      hotplate_off_cmd   = 2'b10,
      read_unique_id_cmd = 2'b11
   } gsc_cmd_type;

   typedef enum logic [1:0] {
      op_start = 2'b00,
      op_stop  = 2'b01,
      op_write = 2'b10,
      op_read  = 2'b11
   } gsc_op_type;

   typedef enum logic [3:0] {
      m_powerup = 4'b0000,
      m_idle    = 4'b0001,
      m_start   = 4'b0010,
      m_wbyte   = 4'b0011,
      m_wstop   = 4'b0100,
      m_exec    = 4'b0101,
      m_rstart  = 4'b0110,
      m_rbyte   = 4'b0111,
      m_rstop   = 4'b1000,
      m_finish  = 4'b1001
   } gsc_state_type;

   // Bitwise CRC-8, MSB first, no reflection
   function automatic logic [7:0] gsc_crc8(input logic [15:0] word);
      logic [7:0] crc;
      crc = CRC_INIT;
      for (int i = 15; i >= 0; i--)
      begin
         if (crc[7] ^ word[i])
            crc = {crc[6:0], 1'b0} ^ CRC_POLY;
         else
            crc = {crc[6:0], 1'b0};
      end
      return crc ^ CRC_XOR;
   endfunction : gsc_crc8

endpackage : gsc_pkg

/* gsc_byte_if.sv */
// Byte-level request and answer between the sequencer and the bit engine.
// Both ends run on the system clock.
`timescale 1ns/100ps
interface gsc_byte_if
   import gsc_pkg::*;
;
   logic       op_valid;
   gsc_op_type op;
   logic [7:0] wdata;
   logic       send_ack;
   logic       done;
   logic [7:0] rdata;
   logic       got_ack;

   modport ctrl   (output op_valid, op, wdata, send_ack, input  done, rdata, got_ack);
   modport engine (input  op_valid, op, wdata, send_ack, output done, rdata, got_ack);
endinterface : gsc_byte_if

/* gsc_bit_engine.sv */
// Two-wire bit engine: start, stop, byte write and byte read with ack.
// Assumes op_valid is only raised while no operation is running.
`timescale 1ns/100ps
module gsc_bit_engine
   import gsc_pkg::*;
#(
   parameter int unsigned P_QTR_CYC = SCL_QTR_CYC
)
(
   input  wire logic  i_sys_clk,
   input  wire logic  i_reset_n,
   input  wire logic  i_sda,
   input  wire logic  i_scl,
   output logic       o_sda_oe,
   output logic       o_scl_oe,
   gsc_byte_if.engine bus
);
   logic       sda_ff1, sda_ff2, scl_ff1, scl_ff2;
   logic       active;
   gsc_op_type cur_op;
   logic [15:0] qcnt;
   logic [1:0] qtr;
   logic [3:0] bit_idx;
   logic [7:0] shreg;
   logic       ack_low;
   logic       stalled, tick, last_bit;
   logic       first_low, next_low;

   // Pull SDA low for a bit slot: data zeros on write, ack slot on read
   function automatic logic drive_low(input gsc_op_type op, input logic [3:0] idx,
                                      input logic bitval, input logic ack);
      if (op == op_write)
         return (idx < BYTE_BITS) && !bitval;
      else
         return (idx == BYTE_BITS) && ack;
   endfunction : drive_low

   // Released SCL still low means the target stretches the clock
   assign stalled   = !o_scl_oe && !scl_ff2;
   assign tick      = active && !stalled && (qcnt == 16'(P_QTR_CYC - 1));
   assign last_bit  = (bit_idx == BYTE_BITS);
   assign first_low = drive_low(bus.op, 4'h0, bus.wdata[7], bus.send_ack);
   assign next_low  = drive_low(cur_op, bit_idx + 4'h1, shreg[7], ack_low);

   // Pin synchronisers
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         {sda_ff1, sda_ff2, scl_ff1, scl_ff2} <= 4'hf;
      end
      else
      begin
         {sda_ff1, sda_ff2, scl_ff1, scl_ff2} <= {i_sda, sda_ff1, i_scl, scl_ff1};
      end
   end

   // Quarter-period sequencer; SDA only changes while SCL is low (data), counter holds while SCL is stretched
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         active <= 1'b0; cur_op <= op_start; qcnt <= 16'h0000; qtr <= 2'h0;
         bit_idx <= 4'h0; shreg <= 8'h00; ack_low <= 1'b0; o_sda_oe <= 1'b0;
         o_scl_oe <= 1'b0; bus.done <= 1'b0; bus.rdata <= 8'h00; bus.got_ack <= 1'b0;
      end
      else
      begin
         bus.done <= 1'b0;
         if (!active && bus.op_valid)
         begin
            active <= 1'b1; cur_op <= bus.op; shreg <= bus.wdata; ack_low <= bus.send_ack;
            qcnt <= 16'h0000; qtr <= 2'h0; bit_idx <= 4'h0;
            if (bus.op == op_stop)
               o_sda_oe <= 1'b1;
            else if (bus.op != op_start)
               o_sda_oe <= first_low;
         end
         else if (tick)
         begin
            qcnt <= 16'h0000;
            qtr  <= qtr + 2'h1;
            case (cur_op)
               op_start:
               begin
                  if (qtr == 2'h0) o_sda_oe <= 1'b1;   // SDA falls with SCL high
                  if (qtr == 2'h1) o_scl_oe <= 1'b1;
                  if (qtr == 2'h3) begin active <= 1'b0; bus.done <= 1'b1; end
               end
               op_stop:
               begin
                  if (qtr == 2'h0) o_scl_oe <= 1'b0;
                  if (qtr == 2'h1) o_sda_oe <= 1'b0;   // SDA rises with SCL high
                  if (qtr == 2'h3) begin active <= 1'b0; bus.done <= 1'b1; end
               end
               default:
               begin
                  if (qtr == 2'h0) o_scl_oe <= 1'b0;
                  if (qtr == 2'h1 && !last_bit) shreg <= {shreg[6:0], sda_ff2};  // MSB first
                  if (qtr == 2'h1 && last_bit) bus.got_ack <= !sda_ff2;
                  if (qtr == 2'h2) o_scl_oe <= 1'b1;
                  if (qtr == 2'h3 && last_bit)
                  begin
                     active <= 1'b0; bus.done <= 1'b1; bus.rdata <= shreg; o_sda_oe <= 1'b0;
                  end
                  else if (qtr == 2'h3)
                  begin
                     bit_idx  <= bit_idx + 4'h1;
                     o_sda_oe <= next_low;
                  end
               end
            endcase
         end
         else if (active && !stalled)
            qcnt <= qcnt + 16'h0001;
      end
   end

endmodule : gsc_bit_engine

/* gsc_sensor_model.sv */
// Behavioural gas sensor, target side of the two-wire link.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
`timescale 1ns/100ps
module gsc_sensor_model
(
   input  wire logic i_scl,
   input  wire logic i_sda,
   input  wire logic i_slow,
   input  wire logic i_fail,
   input  wire logic i_bad_crc,
   output logic      o_sda_oe
);
   logic [7:0]  q[$];
   logic [7:0]  b;
   logic [15:0] c;
   logic [47:0] p;
   logic        m;
   realtime     rdy;
   // Own checksum, so the host helper is never trusted
   function automatic logic [7:0] crc(input logic [15:0] w);
      crc = 8'hff;
      for (int i = 15; i >= 0; i--)
         crc = {crc[6:0], 1'b0} ^ (crc[7] ^ w[i] ? 8'h31 : 8'h00);
   endfunction : crc
   function automatic void put(input logic [15:0] w);
      q.push_back(w[15:8]);
      q.push_back(w[7:0]);
      q.push_back(crc(w) ^ {7'h0, i_bad_crc});
   endfunction : put
   task automatic rx();
      repeat (8) @(posedge i_scl) b = {b[6:0], i_sda};
   endtask : rx
   task automatic ack(input logic a);
      @(negedge i_scl) #1 o_sda_oe = a;
      @(negedge i_scl) #1 o_sda_oe = 1'b0;
   endtask : ack
   task automatic tx(input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
      begin
         o_sda_oe = ~v[i];
         @(negedge i_scl) #1;
      end
      o_sda_oe = 1'b0;
      @(posedge i_scl) m = ~i_sda;
      @(negedge i_scl) #1;
   endtask : tx
   // One frame per start; headers refused while busy
   initial
   begin
      o_sda_oe = 1'b0;
      rdy = 0;
      forever
      begin
         @(negedge i_sda iff i_scl);
         rx();
         m = b[7:1] == 7'h59 && $realtime >= rdy;
         ack(m);
         if (m && !b[0])
         begin
            repeat (2)
            begin
               rx();
               c = {c[7:0], b};
               ack(1'b1);
            end
            repeat (c == 16'h260f ? 6 : 0)
            begin
               rx();
               p = {p[39:0], b};
               ack(1'b1);
            end
            rdy = $realtime + (i_slow ? 5000 : 800);
            q.delete();
            case (c)
               16'h260f: put(crc(p[47:32]) == p[31:24] && crc(p[23:8]) == p[7:0] ? p[47:32] ^ p[23:8] : 16'hffff);
               16'h280e: put({i_fail ? 8'h4b : 8'hd4, 8'h00});
               16'h3682: for (int k = 1; k < 6; k += 2) put({k[7:0], k[7:0] + 8'h1});
               default: rdy = 0;
            endcase
         end
         else if (m)
         begin
            while (m)
               tx(q.size() != 0 ? q.pop_front() : 8'hff);
            q.delete();
         end
      end
   end
endmodule : gsc_sensor_model

/* gsc_sensor_host_chk.sv */
// Port-level checks of the sensor host.
// Bound into every host instance below.
`timescale 1ns/100ps
module gsc_sensor_host_chk
   import gsc_pkg::*;
#(
   parameter int unsigned P_PWRUP_CYC = PWRUP_CYC
)
(
   input wire logic        i_sys_clk,
   input wire logic        i_reset_n,
   input wire logic        i_cmd_valid,
   input wire logic        o_scl_oe,
   input wire logic        o_ready,
   input wire logic        o_done,
   input wire logic [47:0] o_result,
   input wire logic        o_crc_ok,
   input wire logic        o_self_pass
);
   int unsigned cyc;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Cycles since reset, saturating
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
      if (!i_reset_n)
         cyc <= 0;
      else if (cyc <= P_PWRUP_CYC)
         cyc <= cyc + 1;
   property p_pwrup; cyc < P_PWRUP_CYC |-> !o_ready && !o_scl_oe; endproperty
   a_pwrup: assert property (p_pwrup) else $error("bus used too early");
   property p_take; i_cmd_valid && o_ready |=> !o_ready; endproperty
   a_take: assert property (p_take) else $error("ready after take");
   property p_low; $rose(o_scl_oe) |-> o_scl_oe [*7]; endproperty
   a_low: assert property (p_low) else $error("clock low too short");
   property p_high; $fell(o_scl_oe) |-> !o_scl_oe [*3]; endproperty
   a_high: assert property (p_high) else $error("clock high too short");
   property p_done; o_done |=> !o_done; endproperty
   a_done: assert property (p_done) else $error("done too long");
   property p_rdy; o_done |-> o_ready; endproperty
   a_rdy: assert property (p_rdy) else $error("not ready at done");
   property p_hold; !o_done |-> $stable(o_result); endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_pass; o_done && o_self_pass |-> o_result[15:8] == SELF_PASS_BYTE && o_crc_ok; endproperty
   a_pass: assert property (p_pass) else $error("bad pass flag");
endmodule : gsc_sensor_host_chk
bind gsc_sensor_host gsc_sensor_host_chk #(.P_PWRUP_CYC(P_PWRUP_CYC)) chk_u (.i_sys_clk, .i_reset_n, .i_cmd_valid,
   .o_scl_oe, .o_ready, .o_done, .o_result, .o_crc_ok, .o_self_pass);

/* gsc_sensor_host_tb.sv */
// Self-checking bench: host against the behavioural sensor.
// Assumes pull-ups on both lines, modelled as wired-AND.
`timescale 1ns/100ps
module gsc_sensor_host_tb
   import gsc_pkg::*;
;
   typedef struct {gsc_cmd_type s; logic c; logic [15:0] r, t; logic [47:0] e; logic p, h;} gsc_row_type;
   gsc_row_type rows[6] = '{'{measure_raw_cmd, 0, 0, 0, 48'he666, 0, 1},
      '{measure_raw_cmd, 1, 16'h1234, 16'h00ff, 48'h12cb, 0, 1}, '{run_self_check_cmd, 0, 0, 0, 48'hd400, 1, 1},
      '{hotplate_off_cmd, 0, 0, 0, 0, 0, 0}, '{run_self_check_cmd, 0, 0, 0, 48'hd400, 1, 0},
      '{read_unique_id_cmd, 0, 0, 0, 48'h010203040506, 0, 0}};
   logic        clk = 0, rst_n = 0, vld = 0, comp = 0, slow = 0, fail = 0, bad = 0;
   logic        sda_oe, scl_oe, sen_oe, rdy, done, crc_ok, nack, pass, hot, sda_o, scl_o;
   logic [15:0] rh = 0, tp = 0;
   logic [47:0] res;
   gsc_cmd_type sel = measure_raw_cmd;
   int          fail_count = 0, checks = 0, n;
   wire         sda = ~(sda_oe | sen_oe);
   wire         scl = ~scl_oe;
   // Short counts keep the run brief; the retry gap keeps its default, the short wait
   gsc_sensor_host #(.P_SCL_QTR_CYC(4), .P_PWRUP_CYC(20), .P_MEAS_CYC(200), .P_TEST_CYC(300),
      .P_SHORT_CYC(100)) dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_cmd_valid(vld), .i_cmd_sel(sel),
      .i_comp_en(comp), .i_rh_ticks(rh), .i_temp_ticks(tp), .i_sda(sda), .i_scl(scl), .o_sda_out(sda_o),
      .o_sda_oe(sda_oe), .o_scl_out(scl_o), .o_scl_oe(scl_oe), .o_ready(rdy), .o_done(done), .o_result(res),
      .o_crc_ok(crc_ok), .o_nack_err(nack), .o_self_pass(pass), .o_hotplate_on(hot));
   gsc_sensor_model sen_u (.i_scl(scl), .i_sda(sda), .i_slow(slow), .i_fail(fail), .i_bad_crc(bad), .o_sda_oe(sen_oe));
   always #4 clk = ~clk;
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic wait_rdy();
      repeat (100)
         if (rdy !== 1'b1)
            @(posedge clk) #1;
      chk(rdy, 1'b1);
   endtask : wait_rdy
   // Command taken at the next edge, then wait for done
   task automatic run(input gsc_cmd_type s, input logic c, input logic [15:0] r, input logic [15:0] t);
      sel = s;
      comp = c;
      rh = r;
      tp = t;
      vld = 1'b1;
      @(posedge clk) #1 vld = 1'b0;
      repeat (20000)
         if (done !== 1'b1)
            @(posedge clk) #1;
      chk(done, 1'b1);
   endtask : run
   // Watchdog against a hung bus
   initial
   begin
      #700000;
      fail_count++;
      conclude();
   end
   initial
   begin
      @(posedge clk) #1 chk({rdy, done, sda_oe, scl_oe}, 0);
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      wait_rdy();
      foreach (rows[i])
      begin
         run(rows[i].s, rows[i].c, rows[i].r, rows[i].t);
         chk({crc_ok, nack, hot, sda_o, scl_o}, {2'b10, rows[i].h, 2'b00});
         if (rows[i].s != hotplate_off_cmd)
            chk(res, rows[i].e);
         if (rows[i].s == run_self_check_cmd)
            chk(pass, rows[i].p);
      end
      slow = 1'b1;
      run(measure_raw_cmd, 0, 0, 0);
      chk({nack, res}, 49'he666);
      fail = 1'b1;
      run(run_self_check_cmd, 0, 0, 0);
      chk({pass, crc_ok, res[15:8]}, 10'h14b);
      // Reset while the host waits out the self-check
      sel = run_self_check_cmd;
      vld = 1'b1;
      @(posedge clk) #1 vld = 1'b0;
      n = 0;
      while (n < 40)
         @(posedge clk) #1 n = scl_oe ? 0 : n + 1;
      rst_n = 1'b0;
      #1 chk({rdy, sda_oe, scl_oe, hot}, 0);
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      wait_rdy();
      bad = 1'b1;
      run(read_unique_id_cmd, 0, 0, 0);
      chk({crc_ok, res}, 49'h010203040506);
      conclude();
   end
endmodule : gsc_sensor_host_tb
